/* hw/rtw_consts.vh */
// Constants for the ripple timer, periodic interrupt and watchdog block.
// Assumes an 8-bit internal CPU bus with 16-bit addresses.
`ifndef RTW_CONSTS_VH
`define RTW_CONSTS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define RTW_ADDR_TSC 16'h0008
`define RTW_ADDR_CNT 16'h0009
`define RTW_ADDR_WDS 16'h03f0

// ----------------------------------------
// Status/control field positions
// ----------------------------------------
`define RTW_B_OVF_FLAG 7
`define RTW_B_PER_FLAG 6
`define RTW_B_OVF_IE 5
`define RTW_B_PER_IE 4
`define RTW_B_OVF_ACK 3
`define RTW_B_PER_ACK 2
`define RTW_B_RATE_HI 1
`define RTW_B_RATE_LO 0
`define RTW_B_WD_SVC 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RTW_RATE_RST 2'h3
`define RTW_BYTE_ZERO 8'h00

// ----------------------------------------
// Chain geometry and timing counts
// ----------------------------------------
`define RTW_PRE_BITS 2
`define RTW_CNT_BITS 8
`define RTW_CHAIN_BITS 17
`define RTW_OVF_TAP 5'h0a
`define RTW_PER_BASE 5'h0e
`define RTW_WD_BITS 4
`define RTW_WD_LIMIT 4'h8
`define RTW_DLY_BITS 12
`define RTW_DLY_LONG 12'hfe0
`define RTW_DLY_SHORT 12'h010

// ----------------------------------------
// Sequencer states
// ----------------------------------------
`define RTW_S_DELAY 2'h0
`define RTW_S_RUN 2'h1
`define RTW_S_STOP 2'h2

`endif

/* hw/rtw_chain.v */
// Free-running divider chain: prescaler, 8-bit counter and periodic taps.
// Assumes the ungated timer clock is clk_i itself; clear has priority over run.
`timescale 1ns/1ps
`default_nettype none
`include "rtw_consts.vh"

module rtw_chain #(
	parameter CHAIN_BITS = `RTW_CHAIN_BITS
) (
	input wire clk_i,             // Ungated timer clock
	input wire clr_i,             // Clear whole chain
	input wire run_i,             // Advance chain
	input wire [1:0] rate_i,      // Periodic tap select
	output wire [7:0] count_o,    // Visible 8-bit count
	output wire ovf_o,            // Counter wraps this cycle
	output wire tap_o             // Selected tap fires this cycle
);

	reg [CHAIN_BITS-1:0] chain;

	// True when every chain bit below position n is one
	function ones_below;
		input [CHAIN_BITS-1:0] v;
		input [4:0] n;
		integer k;
		begin
			ones_below = 1'b1;
			for (k = 0; k < CHAIN_BITS; k = k + 1) begin
				if ((k < n) && !v[k])
					ones_below = 1'b0;
			end
		end
	endfunction

	// Chain counter, one step per clock
	always @(posedge clk_i) begin
		if (clr_i) begin
			chain <= {CHAIN_BITS{1'b0}};
		end else if (run_i) begin
			chain <= chain + {{(CHAIN_BITS-1){1'b0}}, 1'b1};
		end
	end

	// Counter value and chain events
	assign count_o = chain[`RTW_PRE_BITS+`RTW_CNT_BITS-1:`RTW_PRE_BITS];
	assign ovf_o = run_i && !clr_i && ones_below(chain, `RTW_OVF_TAP);
	assign tap_o = run_i && !clr_i && ones_below(chain, `RTW_PER_BASE + {3'h0, rate_i});

endmodule
`default_nettype wire

/* hw/rtw_watchdog.v */
// Final watchdog stage counting eight periodic ticks.
// Assumes tick_i is a one-cycle pulse from the selected periodic tap.
`timescale 1ns/1ps
`default_nettype none
`include "rtw_consts.vh"

module rtw_watchdog (
	input wire clk_i,            // System clock
	input wire clr_i,            // Clear stage
	input wire en_i,             // Watchdog enabled by option
	input wire svc_i,            // Service pulse
	input wire tick_i,           // Periodic tick
	output reg bite_o            // Expiry pulse
);

	reg [`RTW_WD_BITS-1:0] wd_count;

	// Eight-tick counter; servicing clears only this stage
	always @(posedge clk_i) begin
		if (clr_i || !en_i) begin
			wd_count <= {`RTW_WD_BITS{1'b0}};
			bite_o <= 1'b0;
		end else if (svc_i) begin
			wd_count <= {`RTW_WD_BITS{1'b0}};
			bite_o <= 1'b0;
		end else if (tick_i && (wd_count == `RTW_WD_LIMIT - 4'h1)) begin
			wd_count <= {`RTW_WD_BITS{1'b0}};
			bite_o <= 1'b1;
		end else begin
			if (tick_i)
				wd_count <= wd_count + 4'h1;
			bite_o <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* hw/rtw_timer.v */
// Top of the ripple timer: register access, flags, reset and stop sequencing.
// Assumes the CPU bus runs on clk_i; strap and reset pins arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
`include "rtw_consts.vh"

// What this block does
// - Count up once per four timer clocks
// - Timer keeps running in wait or halt
// - Counter readable at $09, read-only, reset clears
// - Overflow flag set on counter wrap
// - Power-on delay 4064 or 16, then clear
// - External reset clears the whole chain
// - Periodic tap selects divide 2^14 to 2^17
// - Rate select bits reset to slowest rate
// - Periodic flag set when selected tap fires
// - Interrupt when any flag and enable set
// - Flags clear only through acknowledge bits
// - Acknowledge bits 2,3 write-only, read zero
// - Reset clears both flags and enables
// - Eight periodic ticks expire watchdog, internal reset
// - Timeout between seven and eight periods
// - Writing zero service bit clears final stage
// - Service address reads user memory byte
// - Watchdog enabled by fixed option bit
// - Stop clears timer; exit delays, clears, resumes
// - Halt option treats stop as wait
// - Timer runs in wait; interrupt wakes CPU
module rtw_timer (
	input wire clk_i,              // System and timer clock
	input wire rst_n_i,            // Power-on reset, active low
	input wire ext_rst_n_i,        // Reset pin, active low, async
	input wire wd_enable_i,        // Watchdog option strap, async
	input wire long_delay_i,       // Long startup delay strap, async
	input wire halt_mode_i,        // Stop-as-halt strap, async
	input wire stop_i,             // CPU entering stop, level
	input wire stop_exit_i,        // Wake request while stopped
	input wire [15:0] addr_i,      // Bus address
	input wire wr_en_i,            // Bus write strobe
	input wire rd_en_i,            // Bus read strobe
	input wire [7:0] wdata_i,      // Bus write data
	input wire [7:0] ee_byte_i,    // User memory byte at service address
	output reg [7:0] rdata_o,      // Bus read data, one cycle late
	output wire irq_o,             // Timer interrupt request
	output reg cpu_reset_o,        // Internal reset to the CPU
	output reg stab_busy_o         // Startup or wake delay running
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	reg [3:0] sync_a;
	reg [3:0] sync_b;
	wire ext_rst_act;
	wire wd_en;
	wire long_dly;
	wire halt_mode;

	// Two flops on every asynchronous pin
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			sync_a <= 4'h1;
			sync_b <= 4'h1;
		end else begin
			sync_a <= {halt_mode_i, long_delay_i, wd_enable_i, ext_rst_n_i};
			sync_b <= sync_a;
		end
	end

	assign ext_rst_act = !sync_b[0];
	assign wd_en = sync_b[1];
	assign long_dly = sync_b[2];
	assign halt_mode = sync_b[3];

	// ----------------------------------------
	// Sequencer and reset sources
	// ----------------------------------------
	reg [1:0] state;
	reg [1:0] next_state;
	reg [`RTW_DLY_BITS-1:0] dly_count;
	wire [`RTW_DLY_BITS-1:0] dly_last;
	wire dly_done;
	wire wd_bite;
	wire soft_rst;
	wire hard_rst;
	wire chain_clr;
	wire chain_run;
	wire running;

	// Internal resets: reset pin or watchdog expiry
	assign soft_rst = ext_rst_act || wd_bite;
	assign hard_rst = !rst_n_i || soft_rst;
	assign dly_last = (long_dly ? `RTW_DLY_LONG : `RTW_DLY_SHORT) - 12'h001;
	assign dly_done = (state == `RTW_S_DELAY) && (dly_count == dly_last);
	assign running = (state == `RTW_S_RUN);

	// Next state selection
	always @* begin
		next_state = state;
		case (state)
			`RTW_S_DELAY: begin
				if (dly_done)
					next_state = `RTW_S_RUN;
			end
			`RTW_S_RUN: begin
				if (stop_i && !halt_mode)
					next_state = `RTW_S_STOP;
			end
			`RTW_S_STOP: begin
				if (stop_exit_i)
					next_state = `RTW_S_DELAY;
			end
			default: begin
				next_state = `RTW_S_DELAY;
			end
		endcase
	end

	// State register and delay counter
	always @(posedge clk_i) begin
		if (hard_rst) begin
			state <= `RTW_S_DELAY;
			dly_count <= {`RTW_DLY_BITS{1'b0}};
		end else begin
			state <= next_state;
			if (next_state == `RTW_S_DELAY && state == `RTW_S_DELAY)
				dly_count <= dly_count + 12'h001;
			else
				dly_count <= {`RTW_DLY_BITS{1'b0}};
		end
	end

	// CPU reset held until the startup delay ends
	always @(posedge clk_i) begin
		if (hard_rst) begin
			cpu_reset_o <= 1'b1;
			stab_busy_o <= 1'b1;
		end else begin
			if (dly_done)
				cpu_reset_o <= 1'b0;
			stab_busy_o <= (next_state == `RTW_S_DELAY);
		end
	end

	// Chain runs in delay and run, held clear in stop
	assign chain_clr = hard_rst || dly_done || (state == `RTW_S_STOP);
	assign chain_run = (state != `RTW_S_STOP);

	// ----------------------------------------
	// Counter chain and watchdog stage
	// ----------------------------------------
	reg [1:0] rate_sel;
	wire [7:0] count_val;
	wire ovf_raw;
	wire tap_raw;
	wire ovf_evt;
	wire per_evt;
	wire wd_svc;
	wire tsc_wr;

	rtw_chain #(
		.CHAIN_BITS(`RTW_CHAIN_BITS)
	) u_chain (
		.clk_i(clk_i),
		.clr_i(chain_clr),
		.run_i(chain_run),
		.rate_i(rate_sel),
		.count_o(count_val),
		.ovf_o(ovf_raw),
		.tap_o(tap_raw)
	);

	// Events only count once the timer is running
	assign ovf_evt = ovf_raw && running;
	assign per_evt = tap_raw && running;

	// Writing zero to the service bit services the watchdog
	assign wd_svc = wr_en_i && (addr_i == `RTW_ADDR_WDS) && !wdata_i[`RTW_B_WD_SVC];

	rtw_watchdog u_watchdog (
		.clk_i(clk_i),
		.clr_i(chain_clr),
		.en_i(wd_en),
		.svc_i(wd_svc),
		.tick_i(per_evt),
		.bite_o(wd_bite)
	);

	// ----------------------------------------
	// Status/control register
	// ----------------------------------------
	reg ovf_flag;
	reg per_flag;
	reg ovf_ie;
	reg per_ie;
	wire ovf_ack;
	wire per_ack;

	assign tsc_wr = wr_en_i && (addr_i == `RTW_ADDR_TSC);
	assign ovf_ack = tsc_wr && wdata_i[`RTW_B_OVF_ACK];
	assign per_ack = tsc_wr && wdata_i[`RTW_B_PER_ACK];

	// Enables and rate bits written by software
	always @(posedge clk_i) begin
		if (hard_rst) begin
			ovf_ie <= 1'b0;
			per_ie <= 1'b0;
			rate_sel <= `RTW_RATE_RST;
		end else if (tsc_wr) begin
			ovf_ie <= wdata_i[`RTW_B_OVF_IE];
			per_ie <= wdata_i[`RTW_B_PER_IE];
			rate_sel <= {wdata_i[`RTW_B_RATE_HI], wdata_i[`RTW_B_RATE_LO]};
		end
	end

	// Sticky flags; a same-cycle event beats the acknowledge
	always @(posedge clk_i) begin
		if (hard_rst) begin
			ovf_flag <= 1'b0;
			per_flag <= 1'b0;
		end else begin
			ovf_flag <= ovf_evt || (ovf_flag && !ovf_ack);
			per_flag <= per_evt || (per_flag && !per_ack);
		end
	end

	// Single interrupt, also the wake source from wait
	assign irq_o = (ovf_flag && ovf_ie) || (per_flag && per_ie);

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	reg [7:0] next_rdata;

	// Read mux; acknowledge bits always read zero
	always @* begin
		next_rdata = `RTW_BYTE_ZERO;
		case (addr_i)
			`RTW_ADDR_TSC: begin
				next_rdata[`RTW_B_OVF_FLAG] = ovf_flag;
				next_rdata[`RTW_B_PER_FLAG] = per_flag;
				next_rdata[`RTW_B_OVF_IE] = ovf_ie;
				next_rdata[`RTW_B_PER_IE] = per_ie;
				next_rdata[`RTW_B_RATE_HI] = rate_sel[1];
				next_rdata[`RTW_B_RATE_LO] = rate_sel[0];
			end
			`RTW_ADDR_CNT: begin
				next_rdata = count_val;
			end
			`RTW_ADDR_WDS: begin
				next_rdata = ee_byte_i;
			end
			default: begin
				next_rdata = `RTW_BYTE_ZERO;
			end
		endcase
	end

	// Registered read data, zero when not reading
	always @(posedge clk_i) begin
		if (!rst_n_i)
			rdata_o <= `RTW_BYTE_ZERO;
		else if (rd_en_i)
			rdata_o <= next_rdata;
		else
			rdata_o <= `RTW_BYTE_ZERO;
	end

endmodule
`default_nettype wire

/* sim/rtw_timer_sva.sv */
// Concurrent checks on the timer top, bound to its ports.
// Assumes a synchronous active-low reset on clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "rtw_consts.vh"
module rtw_timer_sva (
	input wire logic clk_i, // Clock
	input wire logic rst_n_i, // Reset
	input wire logic ext_rst_n_i, // Pin reset
	input wire logic wd_enable_i, // Strap
	input wire logic long_delay_i, // Strap
	input wire logic halt_mode_i, // Strap
	input wire logic stop_i, // Stop
	input wire logic stop_exit_i, // Wake
	input wire logic [15:0] addr_i, // Address
	input wire logic wr_en_i, // Write
	input wire logic rd_en_i, // Read
	input wire logic [7:0] wdata_i, // Write data
	input wire logic [7:0] ee_byte_i, // Memory byte
	input wire logic [7:0] rdata_o, // Read data
	input wire logic irq_o, // Interrupt
	input wire logic cpu_reset_o, // Internal reset
	input wire logic stab_busy_o // Delay running
);
	// ----------------------------------------
	// Sequences and properties
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	localparam int BUSY_MAX = 4100;
	int busy_run = 0;
	// Cycles spent in one startup or wake delay, pin reset excluded
	always @(posedge clk_i) begin
		if (!rst_n_i || !ext_rst_n_i || !stab_busy_o)
			busy_run <= 0;
		else
			busy_run <= busy_run + 1;
	end
	sequence s_release;
		$rose(rst_n_i);
	endsequence
	sequence s_delay_done;
		(busy_run <= BUSY_MAX);
	endsequence
	a_rdata_idle: assert property (!rd_en_i |=> rdata_o == 8'h00)
		else $error("read data not idle");
	a_ack_reads_zero: assert property (rd_en_i && addr_i == `RTW_ADDR_TSC |=>
		rdata_o[3:2] == 2'b00) else $error("ack bits read nonzero");
	a_svc_reads_ee: assert property (rd_en_i && addr_i == `RTW_ADDR_WDS |=>
		rdata_o == $past(ee_byte_i)) else $error("service address data wrong");
	a_unmapped_zero: assert property (rd_en_i && addr_i != `RTW_ADDR_TSC &&
		addr_i != `RTW_ADDR_CNT && addr_i != `RTW_ADDR_WDS |=> rdata_o == 8'h00)
		else $error("unmapped read nonzero");
	a_reset_hold: assert property (disable iff (1'b0) !rst_n_i |=>
		cpu_reset_o && stab_busy_o && !irq_o) else $error("reset state wrong");
	a_delay_min: assert property (s_release |-> stab_busy_o [*8])
		else $error("startup delay too short");
	a_delay_bound: assert property (s_delay_done)
		else $error("startup delay never ends");
	a_reset_ends_delay: assert property ($fell(cpu_reset_o) |-> $past(stab_busy_o))
		else $error("reset released outside delay");
	a_pin_reset: assert property (!ext_rst_n_i [*5] |-> cpu_reset_o)
		else $error("pin reset ignored");
endmodule
bind rtw_timer rtw_timer_sva chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.ext_rst_n_i(ext_rst_n_i), .wd_enable_i(wd_enable_i), .long_delay_i(long_delay_i),
	.halt_mode_i(halt_mode_i), .stop_i(stop_i), .stop_exit_i(stop_exit_i), .addr_i(addr_i),
	.wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wdata_i(wdata_i), .ee_byte_i(ee_byte_i),
	.rdata_o(rdata_o), .irq_o(irq_o), .cpu_reset_o(cpu_reset_o), .stab_busy_o(stab_busy_o));
`default_nettype wire

/* sim/rtw_cpu_model.sv */
// Bus master standing for the CPU core.
// Assumes read data is valid in the cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
`include "rtw_consts.vh"
module rtw_cpu_model (
	input wire logic clk_i, // Bus clock
	input wire logic [7:0] rdata_i, // Read data
	output logic [15:0] addr_o, // Address
	output logic wr_en_o, // Write strobe
	output logic rd_en_o, // Read strobe
	output logic [7:0] wdata_o // Write data
);
	// ----------------------------------------
	// Bus cycles, lines inverted once released
	// ----------------------------------------
	initial begin
		addr_o = 16'hffff;
		wr_en_o = 1'b0;
		rd_en_o = 1'b0;
		wdata_o = 8'h00;
	end
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = v;
		wr_en_o = 1'b1;
		@(negedge clk_i);
		wr_en_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~v;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(negedge clk_i);
		addr_o = a;
		rd_en_o = 1'b1;
		@(negedge clk_i);
		rd_en_o = 1'b0;
		addr_o = ~a;
		v = rdata_i;
	endtask
	// Service just before any rate change
	task automatic svc();
		wr(`RTW_ADDR_WDS, 8'hfe);
	endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the ripple timer top.
// Assumes the CPU model drives the bus at falling edges.
`timescale 1ns/1ps
`default_nettype none
`include "rtw_consts.vh"
module tb_top;
	logic clk_i = 0, rst_n_i = 0, ext_rst_n_i = 1, stop_i = 0, stop_exit_i = 0;
	logic long_delay_i = 0, halt_mode_i = 0;
	logic wr_en_i, rd_en_i, irq_o, cpu_reset_o, stab_busy_o;
	logic [15:0] addr_i;
	logic [7:0] wdata_i, rdata_o, d, e, ee_byte_i = 8'h00;
	logic [31:0] seed = 32'h551422ff;
	logic [1:0] m_ie;
	int n_errors = 0, checks = 0, cyc = 0;
	// ----------------------------------------
	// Clock, hang guard, design and bus model
	// ----------------------------------------
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			wrap_up();
		end
	end
	rtw_timer dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ext_rst_n_i(ext_rst_n_i),
		.wd_enable_i(1'b1), .long_delay_i(long_delay_i), .halt_mode_i(halt_mode_i), .stop_i(stop_i),
		.stop_exit_i(stop_exit_i), .addr_i(addr_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
		.wdata_i(wdata_i), .ee_byte_i(ee_byte_i), .rdata_o(rdata_o), .irq_o(irq_o),
		.cpu_reset_o(cpu_reset_o), .stab_busy_o(stab_busy_o));
	rtw_cpu_model cpu (.clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i),
		.wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .wdata_o(wdata_i));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 5000 && stab_busy_o !== 1'b0; i++) @(negedge clk_i);
		chk("busy", {7'h00, stab_busy_o}, 8'h00);
	endtask
	task automatic wrap_up();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(negedge clk_i);
		rst_n_i = 1;
		wait_idle();
		cpu.rd(`RTW_ADDR_TSC, d);
		chk("tsc reset", d, 8'h03);
		cpu.rd(`RTW_ADDR_CNT, d);
		repeat (2) @(negedge clk_i);
		cpu.rd(`RTW_ADDR_CNT, e);
		chk("count step", e, d + 8'h01);
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			m_ie = seed[5:4];
			cpu.svc();
			cpu.wr(`RTW_ADDR_TSC, {seed[7:4], 2'b11, i[1:0]});
			cpu.rd(`RTW_ADDR_TSC, d);
			chk("tsc write", d, {2'b00, m_ie, 2'b00, i[1:0]});
		end
		seed = xs(seed);
		ee_byte_i = seed[15:8];
		cpu.rd(`RTW_ADDR_WDS, d);
		chk("svc read", d, seed[15:8]);
		cpu.rd(16'h0010, d);
		chk("unmapped", d, 8'h00);
		m_ie = 2'b10;
		cpu.wr(`RTW_ADDR_TSC, 8'h23);
		repeat (1100) @(negedge clk_i);
		cpu.rd(`RTW_ADDR_TSC, d);
		chk("ovf set", d, {2'b10, m_ie, 4'h3});
		chk("irq on", {7'h00, irq_o}, 8'h01);
		cpu.wr(`RTW_ADDR_TSC, 8'h63);
		cpu.rd(`RTW_ADDR_TSC, d);
		chk("flag write", d, {2'b10, m_ie, 4'h3});
		cpu.wr(`RTW_ADDR_TSC, 8'h2b);
		cpu.rd(`RTW_ADDR_TSC, d);
		chk("ovf ack", d, {2'b00, m_ie, 4'h3});
		chk("irq off", {7'h00, irq_o}, 8'h00);
		cpu.svc();
		m_ie = 2'b01;
		cpu.wr(`RTW_ADDR_TSC, 8'h1c);
		repeat (15000) @(negedge clk_i);
		chk("per early", {7'h00, irq_o}, 8'h00);
		repeat (400) @(negedge clk_i);
		cpu.rd(`RTW_ADDR_TSC, d);
		chk("per set", d, {2'b11, m_ie, 4'h0});
		chk("per irq", {7'h00, irq_o}, 8'h01);
		stop_i = 1;
		repeat (2) @(negedge clk_i);
		stop_i = 0;
		cpu.rd(`RTW_ADDR_CNT, d);
		repeat (8) @(negedge clk_i);
		cpu.rd(`RTW_ADDR_CNT, e);
		chk("stop count", d | e, 8'h00);
		stop_exit_i = 1;
		@(negedge clk_i);
		stop_exit_i = 0;
		@(negedge clk_i);
		chk("wake busy", {6'h00, stab_busy_o, cpu_reset_o}, 8'h02);
		wait_idle();
		cpu.rd(`RTW_ADDR_CNT, d);
		chk("resume", d, 8'h00);
		halt_mode_i = 1;
		repeat (3) @(negedge clk_i);
		stop_i = 1;
		repeat (2) @(negedge clk_i);
		stop_i = 0;
		cpu.rd(`RTW_ADDR_CNT, d);
		repeat (6) @(negedge clk_i);
		cpu.rd(`RTW_ADDR_CNT, e);
		chk("halt count", e, d + 8'h02);
		halt_mode_i = 0;
		long_delay_i = 1;
		ext_rst_n_i = 0;
		repeat (6) @(negedge clk_i);
		chk("pin reset", {7'h00, cpu_reset_o}, 8'h01);
		ext_rst_n_i = 1;
		repeat (4060) @(negedge clk_i);
		chk("long busy", {7'h00, stab_busy_o}, 8'h01);
		repeat (10) @(negedge clk_i);
		chk("long done", {7'h00, stab_busy_o}, 8'h00);
		wait_idle();
		cpu.rd(`RTW_ADDR_TSC, d);
		chk("pin reset tsc", d, 8'h03);
		wrap_up();
	end
endmodule
`default_nettype wire
